// [dv/adc_conversion_control_tb.sv]
// Self-checking bench for the converter control block
// Assumes the core model in adc_core_model.sv and a 100 MHz clock
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module adc_conversion_control_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:1] trig = 7'h00;
  logic gie = 1'b1;
  logic ack = 1'b0;
  logic [9:0] sample = 10'h000;
  logic [7:0] rdata;
  logic irq, core_power, core_start, core_diff, conv_tick;
  logic [3:0] core_pos_in, core_neg_in;
  adc_ctrl_pkg::gain_t core_gain;
  logic [9:0] core_result;
  logic [15:0] seed = 16'h0054;
  logic [15:0] last;
  int num_errors = 0;
  int checked = 0;
  int ticks = 0;
  int starts = 0;

  always #5 clk = ~clk;

  adc_conversion_control dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .trigger_sources(trig), .global_irq_enable(gie),
    .irq_ack(ack), .irq(irq), .core_power(core_power), .core_start(core_start),
    .core_pos_in(core_pos_in), .core_neg_in(core_neg_in), .core_gain(core_gain),
    .core_diff(core_diff), .conv_tick(conv_tick), .core_result(core_result));
  adc_core_model core (.clk(clk), .resetn(resetn), .core_power(core_power),
    .core_start(core_start), .sample(sample), .core_result(core_result));

  // Ticks counted after the start cycle
  always @(posedge clk)
  begin
    if (core_start)
      ticks <= 0;
    else if (conv_tick)
      ticks <= ticks + 1;
    if (core_start)
      starts <= starts + 1;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Expected {diff, gain, pos, neg}
  function automatic logic [10:0] dec(input logic [5:0] c);
    logic [3:0] p, n;
    logic [1:0] g;
    p = 4'h8 + {1'b0, c[2:0]};
    n = c[3] ? 4'hA : 4'h9;
    g = 2'h0;
    if (c[5:3] == 3'b101)
    begin
      p = 4'h8 | {2'h0, c[2], c[0]};
      n = 4'h8 | {2'h0, c[2], 1'b0};
      g = c[1] ? 2'h2 : 2'h1;
    end
    dec = {c < 6'h3E, g, (c < 6'h3E) ? p : c[3:0], n};
  endfunction : dec

  // Expected {high, low}
  function automatic logic [15:0] view(input logic [9:0] r, input logic d, input logic l);
    logic [9:0] s;
    s = d ? r ^ 10'h200 : r;
    view = l ? {s, 6'h00} : {6'h00, s};
  endfunction : view

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic wait_idle(output logic [7:0] v);
    int n;
    n = 0;
    v = 8'h40;
    while (v[6] === 1'b1 && n < 400)
    begin
      rd_reg(8'h7A, v);
      n++;
    end
    `CHK("busy", 1'b0, v[6])
  endtask : wait_idle

  task automatic chk_res(input logic [15:0] e);
    logic [7:0] v;
    rd_reg(8'h78, v);
    `CHK("res_low", e[7:0], v)
    rd_reg(8'h79, v);
    `CHK("res_high", e[15:8], v)
  endtask : chk_res

  task automatic conv(input logic [5:0] c, input logic l, input logic [7:0] ctl, input int len);
    logic [10:0] e;
    logic [7:0] v;
    int k;
    e = dec(c);
    seed = lfsr(seed);
    @(posedge clk);
    sample <= seed[9:0];
    wr_reg(8'h7B, {4'h0, c[5], 3'h0});
    wr_reg(8'h7C, {2'h0, l, c[4:0]});
    k = starts;
    wr_reg(8'h7A, ctl);
    #1 `CHK("diff", e[10], core_diff)
    `CHK("pos", e[7:4], core_pos_in)
    if (e[10])
    begin
      `CHK("neg", e[3:0], core_neg_in)
      `CHK("gain", e[9:8], core_gain)
    end
    wr_reg(8'h7C, {2'h0, l, ~c[4:0]});
    #1 `CHK("pos_hold", e[7:4], core_pos_in)
    wait_idle(v);
    `CHK("ticks", len, ticks)
    `CHK("starts", k + 1, starts)
    `CHK("flag", 1'b1, v[4])
    `CHK("irq", 1'b1, irq)
    chk_res(view(seed[9:0], e[10], l));
    wr_reg(8'h7C, {2'h0, ~l, c[4:0]});
    last = view(seed[9:0], e[10], ~l);
    chk_res(last);
  endtask : conv

  task automatic next_tick(output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (conv_tick !== 1'b1 && n < 300);
    t = int'($time);
  endtask : next_tick

  task automatic end_sim;
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    #500_000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    logic [7:0] v;
    int a, b, k;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(i < 5 ? 8'h78 + i[7:0] : 8'h55, v);
      `CHK("reset_val", 8'h00, v)
    end
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(8'h7A, 8'h80 | i[7:0]);
      next_tick(a);
      next_tick(a);
      next_tick(b);
      `CHK("divider", (i < 2) ? 2 : (1 << i), (b - a) / 10)
    end
    wr_reg(8'h7A, 8'h00);
    for (int c = 8'h28; c < 8'h40; c++)
      conv(c[5:0], c[0], 8'hDB, (c == 8'h28) ? 25 : 13);
    rd_reg(8'h78, v);
    seed = lfsr(seed);
    @(posedge clk);
    sample <= seed[9:0];
    wr_reg(8'h7A, 8'hDB);
    wait_idle(v);
    chk_res(last);
    chk_res(last);
    @(posedge clk);
    gie <= 1'b0;
    #1 `CHK("irq_gie", 1'b0, irq)
    @(posedge clk);
    gie <= 1'b1;
    ack <= 1'b1;
    #1 `CHK("irq_back", 1'b1, irq)
    @(posedge clk);
    ack <= 1'b0;
    #1 `CHK("irq_ack", 1'b0, irq)
    conv(6'h31, 1'b0, 8'hCB, 13);
    wr_reg(8'h7A, 8'h8B);
    rd_reg(8'h7A, v);
    `CHK("w0_keep", 1'b1, v[4])
    wr_reg(8'h7A, 8'h9B);
    rd_reg(8'h7A, v);
    `CHK("w1_clear", 1'b0, v[4])
    wr_reg(8'h7A, 8'hDB);
    repeat (20) @(posedge clk);
    wr_reg(8'h7A, 8'h00);
    #1 `CHK("power", 1'b0, core_power)
    wr_reg(8'h7A, 8'h8B);
    rd_reg(8'h7A, v);
    `CHK("aborted", 8'h8B, v)
    conv(6'h30, 1'b0, 8'hCB, 25);
    wr_reg(8'h7B, 8'h03);
    k = starts;
    @(posedge clk);
    trig[3] <= 1'b1;
    repeat (3) @(posedge clk);
    trig[3] <= 1'b0;
    `CHK("no_auto", k, starts)
    wr_reg(8'h7A, 8'hAB);
    trig[5] <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("other_src", k, starts)
    trig[3] <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("trig_start", k + 1, starts)
    wait_idle(v);
    `CHK("trig_ticks", 13, ticks)
    wr_reg(8'h7B, 8'h00);
    k = starts;
    wr_reg(8'h7A, 8'hEB);
    repeat (250) @(posedge clk);
    `CHK("free_run", k + 3, starts)
    wr_reg(8'h7A, 8'h00);
    end_sim();
  end
endmodule : adc_conversion_control_tb

// [dv/adc_core_model.sv]
// Analog core stand-in: latches a sample value on each start pulse
// Assumes the controller samples core_result on the last converter tick
`timescale 1ns/1ps
module adc_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic core_power,
  input wire logic core_start,
  input wire logic [9:0] sample,
  output logic [9:0] core_result
);
  logic [9:0] held;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      held <= 10'h000;
    else if (core_start)
      held <= sample;
    else if (!core_power)
      held <= ~held;
  end
  assign core_result = held;
endmodule : adc_core_model

// [src/adc_channel_decode.sv]
// Channel and gain decoder for the upper selection codes
// Codes below the upper bank pass as single-ended, index from the low bits
`timescale 1ns/1ps
module adc_channel_decode (
  input wire logic [5:0] code,
  output logic [3:0] pos_in,
  output logic [3:0] neg_in,
  output adc_ctrl_pkg::gain_t gain,
  output logic diff,
  output logic reserved
);
  always_comb
  begin
    pos_in = code[3:0];
    neg_in = 4'h0;
    gain = adc_ctrl_pkg::GAIN_1X;
    diff = 1'b0;
    reserved = 1'b0;
    if (code[5:3] == 3'h5)
    begin
      // Gain pairs among inputs 8..11
      pos_in = {2'h2, code[2], code[0]};
      neg_in = {2'h2, code[2], 1'b0};
      gain = code[1] ? adc_ctrl_pkg::GAIN_200X : adc_ctrl_pkg::GAIN_10X;
      diff = 1'b1;
    end
    else if (code[5:4] == 2'h3)
    begin
      pos_in = {1'b1, code[2:0]};
      neg_in = code[3] ? 4'hA : 4'h9;
      diff = 1'b1;
      if (code[3:1] == 3'h7)
      begin
        reserved = 1'b1;
        diff = 1'b0;
      end
    end
  end
endmodule : adc_channel_decode

// [src/adc_conversion_control.sv]
// Control, prescaler, trigger and result logic of a 10-bit SAR converter
// Assumes a single-cycle register port and an analog core that holds
// core_result valid on the tick that ends a conversion
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_conversion_control #(
  parameter int RESULT_W = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:1] trigger_sources,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  output logic irq,
  output logic core_power,
  output logic core_start,
  output logic [3:0] core_pos_in,
  output logic [3:0] core_neg_in,
  output adc_ctrl_pkg::gain_t core_gain,
  output logic core_diff,
  output logic conv_tick,
  input wire logic [RESULT_W-1:0] core_result
);
  logic adc_enable;
  logic auto_trigger_enable;
  logic conversion_done_flag;
  logic conversion_irq_enable;
  logic [2:0] clock_divider_select;
  logic [2:0] trigger_source_select;
  logic [5:0] channel_gain_select;
  logic left_adjust_select;
  adc_ctrl_pkg::conv_state_t state;
  logic [4:0] tick_cnt;
  logic [4:0] conv_len;
  logic first_pending;
  logic [5:0] conv_channel;
  logic [RESULT_W-1:0] result;
  logic locked;
  logic trig_prev;
  logic trig_level;
  logic ctrl_wr;
  logic enabling;
  logic start_wr;
  logic start_auto;
  logic start_now;
  logic start_first;
  logic busy;
  logic done_now;
  logic free_run;
  logic dec_diff;
  logic [RESULT_W-1:0] stored_value;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;
  logic [7:0] next_rdata;

  assign ctrl_wr = wr && addr == `ADDR_CTRL_STATUS;
  assign enabling = ctrl_wr && wdata[`CTRL_ENABLE_BIT] && !adc_enable;
  assign busy = state == adc_ctrl_pkg::ST_CONVERT;
  assign free_run = auto_trigger_enable && trigger_source_select == 3'h0;
  assign done_now = busy && conv_tick && tick_cnt == conv_len - 5'h01;

  // Starts only count while enabled and idle; an enable written low wins
  assign start_wr = ctrl_wr && wdata[`CTRL_START_BIT] && wdata[`CTRL_ENABLE_BIT];
  assign trig_level = trigger_source_select == 3'h0 ? 1'b0
                      : trigger_sources[trigger_source_select];
  assign start_auto = adc_enable && auto_trigger_enable && trig_level && !trig_prev;
  assign start_now = !busy && (start_wr || (start_auto && !(ctrl_wr && !wdata[`CTRL_ENABLE_BIT])));
  assign start_first = first_pending || enabling;
  // A disabling write in the done cycle must not relaunch a free running conversion
  assign core_start = start_now
                      || (done_now && free_run && adc_enable && !(ctrl_wr && !wdata[`CTRL_ENABLE_BIT]));

  adc_prescaler #(
    .CNT_W(7)
  ) u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .run(adc_enable),
    .div_sel(clock_divider_select),
    .tick(conv_tick)
  );

  adc_channel_decode u_decode (
    .code(conv_channel),
    .pos_in(core_pos_in),
    .neg_in(core_neg_in),
    .gain(core_gain),
    .diff(dec_diff),
    .reserved()
  );
  assign core_diff = dec_diff;
  assign core_power = adc_enable;

  // Control and status register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      adc_enable <= 1'b0;
      auto_trigger_enable <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_divider_select <= 3'h0;
    end
    else if (ctrl_wr)
    begin
      adc_enable <= wdata[`CTRL_ENABLE_BIT];
      auto_trigger_enable <= wdata[`CTRL_AUTO_BIT];
      conversion_irq_enable <= wdata[`CTRL_IRQ_EN_BIT];
      clock_divider_select <= wdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trigger_source_select <= 3'h0;
      channel_gain_select <= 6'h00;
      left_adjust_select <= 1'b0;
    end
    else if (wr && addr == `ADDR_CTRL_B)
    begin
      trigger_source_select <= wdata[2:0];
      channel_gain_select[5] <= wdata[`CTRL_B_MUX5_BIT];
    end
    else if (wr && addr == `ADDR_CHANNEL_MUX)
    begin
      left_adjust_select <= wdata[`MUX_LEFT_ADJUST_BIT];
      channel_gain_select[4:0] <= wdata[4:0];
    end
  end

  // Done flag: a completion in the clearing cycle keeps it set
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      conversion_done_flag <= 1'b0;
    else if (done_now)
      conversion_done_flag <= 1'b1;
    else if (irq_ack)
      conversion_done_flag <= 1'b0;
    else if (ctrl_wr && wdata[`CTRL_DONE_BIT])
      conversion_done_flag <= 1'b0;
  end

  assign irq = conversion_done_flag && conversion_irq_enable && global_irq_enable;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      first_pending <= 1'b0;
    else if (start_now)
      first_pending <= 1'b0;
    else if (enabling)
      first_pending <= 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      trig_prev <= 1'b0;
    else
      trig_prev <= trig_level;
  end

  // Conversion sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= adc_ctrl_pkg::ST_IDLE;
      tick_cnt <= 5'h00;
      conv_len <= `CONV_NORMAL_CYCLES;
    end
    else if (ctrl_wr && !wdata[`CTRL_ENABLE_BIT])
    begin
      state <= adc_ctrl_pkg::ST_IDLE;
      tick_cnt <= 5'h00;
    end
    else
    begin
      unique case (state)
        adc_ctrl_pkg::ST_IDLE:
        begin
          if (start_now)
          begin
            state <= adc_ctrl_pkg::ST_CONVERT;
            tick_cnt <= 5'h00;
            conv_len <= start_first ? `CONV_FIRST_CYCLES : `CONV_NORMAL_CYCLES;
          end
        end
        adc_ctrl_pkg::ST_CONVERT:
        begin
          if (done_now)
          begin
            tick_cnt <= 5'h00;
            conv_len <= `CONV_NORMAL_CYCLES;
            if (!free_run)
              state <= adc_ctrl_pkg::ST_IDLE;
          end
          else if (conv_tick)
            tick_cnt <= tick_cnt + 5'h01;
        end
      endcase
    end
  end

  // Channel used by the core is taken only when a conversion begins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      conv_channel <= 6'h00;
    else if (core_start)
      conv_channel <= channel_gain_select;
  end

  // Result store and read lock
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      result <= `RESULT_RESET;
    else if (done_now && !locked && !(rd && addr == `ADDR_RESULT_LOW))
      result <= dec_diff ? {~core_result[RESULT_W-1], core_result[RESULT_W-2:0]}
                         : core_result;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      locked <= 1'b0;
    else if (rd && addr == `ADDR_RESULT_HIGH)
      locked <= 1'b0;
    else if (rd && addr == `ADDR_RESULT_LOW)
      locked <= 1'b1;
  end

  assign stored_value = result;
  always_comb
  begin
    if (left_adjust_select)
    begin
      result_high_byte = stored_value[9:2];
      result_low_byte = {stored_value[1:0], 6'h00};
    end
    else
    begin
      result_high_byte = {6'h00, stored_value[9:8]};
      result_low_byte = stored_value[7:0];
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (addr)
      `ADDR_RESULT_LOW: next_rdata = result_low_byte;
      `ADDR_RESULT_HIGH: next_rdata = result_high_byte;
      `ADDR_CTRL_STATUS:
        next_rdata = {adc_enable, busy, auto_trigger_enable,
                      conversion_done_flag, conversion_irq_enable, clock_divider_select};
      `ADDR_CTRL_B: next_rdata = {4'h0, channel_gain_select[5], trigger_source_select};
      `ADDR_CHANNEL_MUX: next_rdata = {2'h0, left_adjust_select, channel_gain_select[4:0]};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 8'h00;
  end

  done_sets_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    done_now |=> conversion_done_flag
      && (result == $past(core_result)
      || $past(locked || dec_diff || rd && addr == `ADDR_RESULT_LOW)))
    else $error("flag not set at completion");

  start_readback_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == `ADDR_CTRL_STATUS |=> rdata[`CTRL_START_BIT] == $past(busy))
    else $error("start bit does not show busy");

  irq_request_a: assert property (@(posedge clk) disable iff (!resetn)
    irq |-> conversion_done_flag && conversion_irq_enable && global_irq_enable)
    else $error("interrupt without all enables");

  vector_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    irq_ack && !done_now |=> !conversion_done_flag)
    else $error("vector did not clear flag");

  write_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr && !wdata[`CTRL_DONE_BIT] && !irq_ack && conversion_done_flag
    |=> conversion_done_flag)
    else $error("zero write cleared flag");

  disable_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr && !wdata[`CTRL_ENABLE_BIT] |=> !busy && !core_power && !conv_tick)
    else $error("conversion survived disable");

  first_length_a: assert property (@(posedge clk) disable iff (!resetn)
    start_now && start_first |=> conv_len == `CONV_FIRST_CYCLES && busy)
    else $error("first conversion not 25 cycles");

  lock_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    locked || rd && addr == `ADDR_RESULT_LOW |=> $stable(result))
    else $error("result changed while locked");

  channel_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    busy && !core_start |=> $stable(conv_channel))
    else $error("channel changed mid conversion");

  left_view_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == `ADDR_RESULT_HIGH && left_adjust_select |=> rdata == $past(result[9:2]))
    else $error("left adjusted high byte wrong");
endmodule : adc_conversion_control

// [src/adc_ctrl_cfg.svh]
// Register offsets, field positions, reset values and cycle counts
// Assumes an 8-bit register port with byte-wide registers
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define ADDR_RESULT_LOW 8'h78
`define ADDR_RESULT_HIGH 8'h79
`define ADDR_CTRL_STATUS 8'h7A
`define ADDR_CTRL_B 8'h7B
`define ADDR_CHANNEL_MUX 8'h7C

`define CTRL_ENABLE_BIT 7
`define CTRL_START_BIT 6
`define CTRL_AUTO_BIT 5
`define CTRL_DONE_BIT 4
`define CTRL_IRQ_EN_BIT 3
`define CTRL_B_MUX5_BIT 3
`define MUX_LEFT_ADJUST_BIT 5

`define CTRL_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define MUX_RESET 8'h00
`define RESULT_RESET 10'h000

// 25 and 13 converter clock cycles
`define CONV_FIRST_CYCLES 5'h19
`define CONV_NORMAL_CYCLES 5'h0D

`endif

// [src/adc_ctrl_pkg.sv]
// Types shared by the converter control files
// Assumes the cfg header carries all numeric constants
package adc_ctrl_pkg;
  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} gain_t;
  typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_t;
endpackage : adc_ctrl_pkg

// [src/adc_prescaler.sv]
// Converter clock divider: one-cycle tick every 2..128 system clocks
// Assumes run is low whenever the converter is disabled
`timescale 1ns/1ps
module adc_prescaler #(
  parameter int CNT_W = 7
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic [2:0] shift;

  always_comb
  begin
    shift = (div_sel == 3'h0) ? 3'h1 : div_sel;
    limit = CNT_W'((8'h01 << shift) - 8'h01);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt <= '0;
    else if (!run || cnt >= limit)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  assign tick = run && (cnt == limit);
endmodule : adc_prescaler
